// ---- inc/ssp_pkg.sv ----
// Purpose: shared constants and types of the status/protect block
// Assumes: 40 MHz system clock, SPI mode 0 style framing
// Notes: nonvolatile bits are modelled as flops with factory values
`default_nettype none
package ssp_pkg;
  // Instruction bytes
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_SET_LATCH = 8'h06;
  localparam logic [7:0] OPC_CLEAR_LATCH = 8'h04;
  // Status byte bit positions
  localparam int SB_PROTECT_EN = 7;
  localparam int SB_GUARD_HI = 3;
  localparam int SB_GUARD_LO = 2;
  localparam int SB_LATCH = 1;
  localparam int SB_BUSY = 0;
  localparam logic [2:0] SB_UNUSED = 3'h0;
  // Factory values of the nonvolatile bits
  localparam logic PROTECT_EN_RST = 1'h0;
  localparam logic [1:0] GUARD_RST = 2'h0;
  // Array geometry and guarded region starts
  localparam int ADDR_W = 13;
  localparam logic [ADDR_W-1:0] GUARD_QTR_BASE = 13'h1800;
  localparam logic [ADDR_W-1:0] GUARD_HALF_BASE = 13'h1000;
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QTR = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [1:0] GUARD_ALL = 2'h3;
  // Synchronised pin indices
  localparam int PIN_N = 4;
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_WP = 3;
  localparam logic [PIN_N-1:0] SYNC_RST = 4'h9; // Idle levels: select and protect high
  // Self-timed write cycle
  localparam int CLK_MHZ = 40;
  localparam int WRITE_TIME_US = 1000;
  localparam int WRITE_CYCLES_DFLT = WRITE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 24;
  // Serial command states
  typedef enum logic [2:0] {
    SX_IDLE = 3'h0,
    SX_OPCODE = 3'h1,
    SX_STATUS_OUT = 3'h2,
    SX_STATUS_DATA = 3'h3,
    SX_ARM_SET = 3'h4,
    SX_ARM_CLEAR = 3'h5,
    SX_ARM_WRITE = 3'h6,
    SX_SKIP = 3'h7
  } ssp_fsm_e;
endpackage
`default_nettype wire

// ---- inc/ssp_link_if.sv ----
// Purpose: carrier between the core, pin synchroniser and write timer
// Assumes: all members live on clk_sys
// Notes: pin vectors are indexed by the package pin constants
`default_nettype none
interface ssp_link_if;
  logic [ssp_pkg::PIN_N-1:0] lvl;
  logic [ssp_pkg::PIN_N-1:0] rise;
  logic [ssp_pkg::PIN_N-1:0] fall;
  logic tmrStart;
  logic tmrBusy;
  logic tmrDone;
  modport syncSide(output lvl, output rise, output fall);
  modport timerSide(input tmrStart, output tmrBusy, output tmrDone);
  modport coreSide(input lvl, input rise, input fall,
                   input tmrBusy, input tmrDone, output tmrStart);
endinterface
`default_nettype wire

// ---- core/ssp_pin_sync.sv ----
// Purpose: three-stage synchroniser and edge finder for the serial pins
// Assumes: pins change far slower than clk_sys
// Notes: a change counts only once stages two and three agree
`default_nettype none
module ssp_pin_sync (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [ssp_pkg::PIN_N-1:0] pins, // Raw pin levels
  ssp_link_if.syncSide lk // Filtered levels and edges
);
  typedef struct packed {
    logic [ssp_pkg::PIN_N-1:0] s1;
    logic [ssp_pkg::PIN_N-1:0] s2;
    logic [ssp_pkg::PIN_N-1:0] s3;
    logic [ssp_pkg::PIN_N-1:0] filt;
    logic [ssp_pkg::PIN_N-1:0] rise;
    logic [ssp_pkg::PIN_N-1:0] fall;
  } ssp_sync_s;
  ssp_sync_s st_q;
  ssp_sync_s st_d;
  // Stage one feeds stage two only; filter looks at two and three
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < ssp_pkg::PIN_N; i++) begin
      st_d.rise[i] = 1'b0;
      st_d.fall[i] = 1'b0;
      if (st_q.s2[i] == st_q.s3[i] && st_q.s3[i] != st_q.filt[i]) begin
        st_d.filt[i] = st_q.s3[i];
        st_d.rise[i] = st_q.s3[i];
        st_d.fall[i] = ~st_q.s3[i];
      end
    end
  end
  // Reset to pin idle levels, so no false edge follows reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{s1: ssp_pkg::SYNC_RST, s2: ssp_pkg::SYNC_RST, s3: ssp_pkg::SYNC_RST,
                filt: ssp_pkg::SYNC_RST, rise: '0, fall: '0};
    end else begin
      st_q <= st_d;
    end
  end
  assign lk.lvl = st_q.filt;
  assign lk.rise = st_q.rise;
  assign lk.fall = st_q.fall;
endmodule // ssp_pin_sync
`default_nettype wire

// ---- core/ssp_write_timer.sv ----
// Purpose: self-timed internal write cycle
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes: done pulses in the cycle busy falls
`default_nettype none
module ssp_write_timer #(
  parameter int CYCLES = ssp_pkg::WRITE_CYCLES_DFLT
) (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  ssp_link_if.timerSide lk // Start, busy and done
);
  typedef struct packed {
    logic [ssp_pkg::CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } ssp_tmr_s;
  ssp_tmr_s st_q;
  ssp_tmr_s st_d;
  // Count down once per cycle; a second start cannot restart it
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (st_q.busy) begin
      if (st_q.cnt == '0) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 1'b1;
      end
    end else if (lk.tmrStart) begin
      st_d.busy = 1'b1;
      st_d.cnt = ssp_pkg::CNT_W'(CYCLES - 1);
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign lk.tmrBusy = st_q.busy;
  assign lk.tmrDone = st_q.done;
endmodule // ssp_write_timer
`default_nettype wire

// ---- core/ssp_status_protect.sv ----
// Purpose: status byte, write latch and write protection of a serial EEPROM
// Assumes: serial pins are sampled by clk_sys; array sequencer on clk_sys
// Notes: nrst stands for power-up; nonvolatile bits take factory values
//
// Summary of operation
// - Status read answered anytime, even busy
// - Status: enable, three zeros, guards, latch, busy
// - Busy flag shows write cycle, unwritable
// - Latch flag mirrors latch, not writable
// - Set/clear latch ignore hardware protection
// - Guards change only by status write
// - Status byte repeats while select low
// - Guard codes map to protected address ranges
// - Protect enable is writable nonvolatile bit
// - Hardware protect: pin low and enable set
// - Hardware protect blocks status writes only
// - Latch low blocks all; guarded never written
// - Latch clear and output off at power-up
// - Latch cleared when a write completes
// - Status write starts only on well-timed select rise
// - Array access ignored during write cycle
// - Read status 05h, write status 01h
// - Set latch 06h, clear latch 04h
// - MSB first, sample rise, shift on fall
`default_nettype none
module ssp_status_protect #(
  parameter int WRITE_CYCLES = ssp_pkg::WRITE_CYCLES_DFLT
) (
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic csN, // Chip select pin, active low
  input wire logic sck, // Serial clock pin
  input wire logic si, // Serial data in pin
  input wire logic wpN, // Write-protect pin, active low
  output logic so, // Serial data out
  output logic soOeN, // Output enable of so, active low
  input wire logic arrayWrReq, // Array write request pulse
  input wire logic [ssp_pkg::ADDR_W-1:0] arrayWrAddr, // Address of request
  output logic arrayWrGo, // Array write granted pulse
  output logic arrayBusy, // Internal write cycle running
  output logic [7:0] statusView, // Current status byte
  output logic hwProtect // Hardware protection active
);
  // Whole core state in one register
  // pend holds the status data byte until the cycle ends;
  // wrStatus tells the done pulse whether to commit it;
  // the view fields exist only so outputs leave flops
  typedef struct packed {
    ssp_pkg::ssp_fsm_e fsm;
    logic [2:0] bitCnt;
    logic [7:0] inSh;
    logic [7:0] outSh;
    logic [7:0] pend;
    logic wrStatus;
    logic startTmr;
    logic latch;
    logic protEn;
    logic guardHi;
    logic guardLo;
    logic so;
    logic soOeN;
    logic wrGo;
    logic busyView;
    logic [7:0] statusView;
    logic hwProt;
  } ssp_core_s;

  ssp_core_s st_q;
  ssp_core_s st_d;

  ssp_link_if lk ();

  // Serial pins enter the clock domain through three stages
  // Every pin sees the same delay, so data stays lined up with its clock;
  // the price is four clocks of latency on every host edge
  ssp_pin_sync u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pins({wpN, si, sck, csN}),
    .lk(lk.syncSide)
  );

  // Shared timer for array and status write cycles
  // One timer is enough: only one write cycle can run at a time
  ssp_write_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .lk(lk.timerSide)
  );

  // Whether an array address lies in a guarded block
  // Each range ends at the top of the array, so no upper compare
  function automatic logic isGuarded(input logic [1:0] code,
                                     input logic [ssp_pkg::ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (code)
      ssp_pkg::GUARD_NONE: hit = 1'b0;
      ssp_pkg::GUARD_QTR: hit = (addr >= ssp_pkg::GUARD_QTR_BASE);
      ssp_pkg::GUARD_HALF: hit = (addr >= ssp_pkg::GUARD_HALF_BASE);
      ssp_pkg::GUARD_ALL: hit = 1'b1;
    endcase
    return hit;
  endfunction

  // Combinational views of the registered state
  logic csHigh;
  logic csRise;
  logic sckRise;
  logic sckFall;
  logic siLvl;
  logic wpHigh;
  logic busyNow;
  logic hwProtNow;
  logic [7:0] statusNow;
  logic [7:0] byteIn;
  ssp_pkg::ssp_fsm_e fsmNow;
  logic statusWrOk;
  logic arrayWrOk;
  logic [1:0] guardCode;

  // Timing seen from the pins, in clk_sys cycles:
  //   a pin change reaches the core four cycles later;
  //   the core acts in the cycle that sees the filtered edge;
  //   outputs move one cycle after that, five after the pin.
  // Hazards that follow:
  //   serial clock phases shorter than about two cycles are lost;
  //   si must settle no later than the clock edge it rides on;
  //   a select rise acts late, so gaps between frames must
  //   last a few cycles more than the pin delay.
  // Limitations:
  //   the hold function is not handled here;
  //   array reads and writes belong to the sequencer outside,
  //   this block only grants or refuses its write requests.
  // Pin views and derived conditions
  always_comb begin
    csHigh = lk.lvl[ssp_pkg::PIN_CS];
    csRise = lk.rise[ssp_pkg::PIN_CS];
    sckRise = lk.rise[ssp_pkg::PIN_SCK];
    sckFall = lk.fall[ssp_pkg::PIN_SCK];
    siLvl = lk.lvl[ssp_pkg::PIN_SI];
    wpHigh = lk.lvl[ssp_pkg::PIN_WP];
    // Start pulse counts as busy before the timer sees it
    // so a poll in that gap cannot miss the write
    busyNow = lk.tmrBusy | st_q.startTmr;
    // Pin low and enable set; either one alone protects nothing
    hwProtNow = ~wpHigh & st_q.protEn;
    statusNow = 8'h00;
    statusNow[ssp_pkg::SB_PROTECT_EN] = st_q.protEn;
    statusNow[6:4] = ssp_pkg::SB_UNUSED;
    statusNow[ssp_pkg::SB_GUARD_HI] = st_q.guardHi;
    statusNow[ssp_pkg::SB_GUARD_LO] = st_q.guardLo;
    statusNow[ssp_pkg::SB_LATCH] = st_q.latch;
    statusNow[ssp_pkg::SB_BUSY] = busyNow;
    // MSB arrives first, so shift towards the top
    byteIn = {st_q.inSh[6:0], siLvl};
    // Selecting the device moves idle straight into opcode capture
    fsmNow = (st_q.fsm == ssp_pkg::SX_IDLE) ? ssp_pkg::SX_OPCODE : st_q.fsm;
    // Status write needs the latch and no protection or running cycle
    statusWrOk = st_q.latch & ~hwProtNow & ~busyNow;
    // Array write needs the latch and an address outside the guards
    guardCode = {st_q.guardHi, st_q.guardLo};
    arrayWrOk = st_q.latch & ~isGuarded(guardCode, arrayWrAddr);
  end

  // Next state of the whole core
  // Later assignments win, so the order below is the priority:
  // a finished cycle clears the latch, a select rise then applies
  // the armed command, and array requests come last of all
  always_comb begin
    st_d = st_q;
    st_d.startTmr = 1'b0;
    st_d.wrGo = 1'b0;

    // End of a write cycle: commit and drop the latch
    // A set-latch seen in the same cycle still wins further down
    if (lk.tmrDone) begin
      if (st_q.wrStatus) begin
        // Latch and busy positions of the data byte are dropped
        st_d.protEn = st_q.pend[ssp_pkg::SB_PROTECT_EN];
        st_d.guardHi = st_q.pend[ssp_pkg::SB_GUARD_HI];
        st_d.guardLo = st_q.pend[ssp_pkg::SB_GUARD_LO];
      end
      st_d.latch = 1'b0;
    end

    if (csHigh) begin
      // Deselected: output released, framing restarts
      // A frame cut short ends here; partial bytes are dropped
      st_d.fsm = ssp_pkg::SX_IDLE;
      st_d.soOeN = 1'b1;
      st_d.bitCnt = 3'h0;
      // Commands only act on a select rise right after their last bit
      if (csRise) begin
        unique case (st_q.fsm)
          ssp_pkg::SX_ARM_SET: begin
            // Later than the done clear, so a set wins the same cycle
            st_d.latch = 1'b1;
          end
          ssp_pkg::SX_ARM_CLEAR: begin
            // Clearing is allowed even while a cycle runs
            st_d.latch = 1'b0;
          end
          ssp_pkg::SX_ARM_WRITE: begin
            // Latch needed; hardware protect guards status bits only
            // Refused writes start no cycle, but one sent during a status cycle replaces pend and that cycle commits it
            if (statusWrOk) begin
              st_d.startTmr = 1'b1;
              st_d.wrStatus = 1'b1;
            end
          end
          ssp_pkg::SX_IDLE,
          ssp_pkg::SX_OPCODE,
          ssp_pkg::SX_STATUS_OUT,
          ssp_pkg::SX_STATUS_DATA,
          ssp_pkg::SX_SKIP: begin
            // Badly framed or read-only command: nothing happens
            st_d.latch = st_d.latch;
          end
        endcase
      end
    end else begin
      st_d.fsm = fsmNow;
      if (sckRise) begin
        unique case (fsmNow)
          ssp_pkg::SX_OPCODE: begin
            st_d.inSh = byteIn;
            st_d.bitCnt = st_q.bitCnt + 3'h1;
            if (st_q.bitCnt == 3'h7) begin
              st_d.bitCnt = 3'h0;
              // Array read and write opcodes land in skip
              unique case (byteIn)
                ssp_pkg::OPC_READ_STATUS: st_d.fsm = ssp_pkg::SX_STATUS_OUT;
                ssp_pkg::OPC_WRITE_STATUS: st_d.fsm = ssp_pkg::SX_STATUS_DATA;
                ssp_pkg::OPC_SET_LATCH: st_d.fsm = ssp_pkg::SX_ARM_SET;
                ssp_pkg::OPC_CLEAR_LATCH: st_d.fsm = ssp_pkg::SX_ARM_CLEAR;
                default: st_d.fsm = ssp_pkg::SX_SKIP;
              endcase
            end
          end
          ssp_pkg::SX_STATUS_DATA: begin
            st_d.inSh = byteIn;
            st_d.bitCnt = st_q.bitCnt + 3'h1;
            if (st_q.bitCnt == 3'h7) begin
              // Exactly one data byte follows the opcode
              // Whole byte kept; unused positions are masked at commit
              st_d.pend = byteIn;
              st_d.bitCnt = 3'h0;
              st_d.fsm = ssp_pkg::SX_ARM_WRITE;
            end
          end
          ssp_pkg::SX_ARM_SET,
          ssp_pkg::SX_ARM_CLEAR,
          ssp_pkg::SX_ARM_WRITE: begin
            // Any extra clock spoils the framing of the command
            st_d.fsm = ssp_pkg::SX_SKIP;
          end
          ssp_pkg::SX_IDLE,
          ssp_pkg::SX_STATUS_OUT,
          ssp_pkg::SX_SKIP: begin
            // Read and skip states only wait for the select rise
            st_d.bitCnt = st_q.bitCnt;
          end
        endcase
      end
      // Status output shifts after falling edges
      // Bit counter is shared with input, which is idle here
      if (sckFall && fsmNow == ssp_pkg::SX_STATUS_OUT) begin
        st_d.soOeN = 1'b0;
        st_d.bitCnt = st_q.bitCnt + 3'h1;
        if (st_q.bitCnt == 3'h0) begin
          // Fresh snapshot each byte so polling sees busy fall
          st_d.so = statusNow[7];
          st_d.outSh = {statusNow[6:0], 1'b0};
        end else begin
          st_d.so = st_q.outSh[7];
          st_d.outSh = {st_q.outSh[6:0], 1'b0};
        end
      end
    end

    // Array writes: latch, guards and busy decide; ties go to status
    // The grant pulse is the only way the sequencer may program,
    // so a refused request simply sees no grant and may retry
    if (arrayWrReq && !busyNow && !st_d.startTmr) begin
      if (arrayWrOk) begin
        st_d.startTmr = 1'b1;
        st_d.wrStatus = 1'b0;
        st_d.wrGo = 1'b1;
      end
    end

    // Registered views for the outputs
    st_d.busyView = busyNow;
    st_d.statusView = statusNow;
    st_d.hwProt = hwProtNow;
  end

  // Power-up: latch clear, output released, factory protection
  // nrst models power-up, so the latch always starts clear
  // Nonvolatile bits have no true reset; factory values stand in
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{fsm: ssp_pkg::SX_IDLE,
                bitCnt: 3'h0,
                inSh: 8'h00,
                outSh: 8'h00,
                pend: 8'h00,
                wrStatus: 1'b0,
                startTmr: 1'b0,
                latch: 1'b0,
                protEn: ssp_pkg::PROTECT_EN_RST,
                guardHi: ssp_pkg::GUARD_RST[1],
                guardLo: ssp_pkg::GUARD_RST[0],
                so: 1'b0,
                soOeN: 1'b1,
                wrGo: 1'b0,
                busyView: 1'b0,
                statusView: 8'h00,
                hwProt: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Timer start travels through the carrier
  // Registered, so the timer starts one cycle after the decision
  assign lk.tmrStart = st_q.startTmr;

  // Outputs straight from flops
  // No logic between flops and pins keeps output timing clean
  assign so = st_q.so;
  assign soOeN = st_q.soOeN;
  assign arrayWrGo = st_q.wrGo;
  assign arrayBusy = st_q.busyView;
  assign statusView = st_q.statusView;
  assign hwProtect = st_q.hwProt;
endmodule // ssp_status_protect
`default_nettype wire

// ---- sim/ssp_status_protect_props.sv ----
// Purpose: port-level assertions of the status and protect block
// Assumes: bound to the top module, one clock domain
// Notes: status view lags internal state by a cycle, hence $past terms
`default_nettype none
module ssp_status_protect_props #(
  parameter int WRITE_CYCLES = ssp_pkg::WRITE_CYCLES_DFLT
) (
  input wire logic clk_sys, // Clock
  input wire logic nrst, // Reset
  input wire logic csN, // Select
  input wire logic sck, // Serial clock
  input wire logic si, // Data in
  input wire logic wpN, // Protect pin
  input wire logic so, // Data out
  input wire logic soOeN, // Out enable
  input wire logic arrayWrReq, // Array request
  input wire logic [ssp_pkg::ADDR_W-1:0] arrayWrAddr, // Address
  input wire logic arrayWrGo, // Grant
  input wire logic arrayBusy, // Busy
  input wire logic [7:0] statusView, // Status
  input wire logic hwProtect // Hw protect
);
  int busyCnt_q;
  logic grd;
  // Busy length, checked against the timer parameter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busyCnt_q <= 0;
    end else begin
      busyCnt_q <= arrayBusy ? busyCnt_q + 1 : 0;
    end
  end
  // Address inside the guarded range
  assign grd = (statusView[3:2] == 2'h3) || (statusView[3:2] == 2'h2 && arrayWrAddr >= 13'h1000)
    || (statusView[3:2] == 2'h1 && arrayWrAddr >= 13'h1800);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  a_unused_zero: assert property (statusView[6:4] == 3'h0)
    else $error("unused status bits set");
  a_pin_high_off: assert property (wpN [*8] |-> !hwProtect)
    else $error("protect with pin high");
  a_pin_low_on: assert property (
    (!wpN) [*8] ##0 (statusView[7] && $past(statusView[7])) |-> hwProtect)
    else $error("protect missing");
  a_grant_allowed: assert property (
    arrayWrGo |-> $past(arrayWrReq && statusView[1] && !grd))
    else $error("grant without latch or in guarded block");
  a_grant_busy: assert property (arrayWrGo |=> !arrayWrGo ##[0:1] arrayBusy)
    else $error("grant not followed by busy");
  a_busy_len: assert property ($fell(arrayBusy) |->
    busyCnt_q >= WRITE_CYCLES - 1 && busyCnt_q <= WRITE_CYCLES + 1)
    else $error("write cycle length wrong");
  a_busy_flag: assert property (arrayWrGo |=> statusView[0] [*8])
    else $error("busy flag disagrees");
  a_done_clears: assert property ($fell(arrayBusy) |-> ##[0:3] !statusView[1])
    else $error("latch kept after write");
  a_idle_off: assert property (csN [*8] |-> soOeN)
    else $error("output driven while deselected");
  a_so_on_fall: assert property (!soOeN && $changed(so) |-> $past(sck, 6) && !$past(sck, 2))
    else $error("output moved off a falling edge");
  a_hw_keep: assert property (hwProtect && $past(hwProtect) |->
    $stable(statusView[7]) && $stable(statusView[3:2]))
    else $error("status changed while protected");
  c_grant: cover property (arrayWrGo);
  c_protect: cover property ($rose(hwProtect));
  c_out: cover property (!soOeN);
endmodule // ssp_status_protect_props
`default_nettype wire

// ---- sim/ssp_host_model.sv ----
// Purpose: serial bus master stand-in for the status block
// Assumes: mode 0, 200 ns serial clock, clock idle low
// Notes: a released data line shows the inverse of its last level
`default_nettype none
module ssp_host_model (
  output logic csN, // Select, active low
  output logic sck, // Serial clock
  output logic si, // Data to device
  input wire logic so, // Data from device
  input wire logic soOeN // Device drive, active low
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle pins, clock stands still outside frames
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // One frame, n bits from tx[23] down; late sample since so lags the fall
  task automatic frame(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = 24'h0;
    csN = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      si = tx[23-i]; // MSB first
      #100 sck = 1'b1;
      #95 rx = {rx[22:0], soOeN ? ~rx[0] : so};
      #5 sck = 1'b0;
    end
    #100 csN = 1'b1; // Release after the last bit
    si = ~si;
    #400;
  endtask
endmodule // ssp_host_model
`default_nettype wire

// ---- sim/ssp_status_protect_tb_top.sv ----
// Purpose: self-checking bench of the status and protect block
// Assumes: write cycle shortened to WCYC clocks
// Notes: frames come from the host stand-in, array requests from here
`default_nettype none
module ssp_status_protect_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WCYC = 400;
  localparam int LIMIT = 40000;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wpN = 1'b1;
  logic arrayWrReq = 1'b0;
  logic [ssp_pkg::ADDR_W-1:0] arrayWrAddr = 13'h0000;
  logic csN, sck, si, so, soOeN, arrayWrGo, arrayBusy, hwProtect, e;
  logic [7:0] statusView;
  logic [23:0] rx;
  logic [1:0] g;
  logic [12:0] adr [4] = '{13'h0FFF, 13'h1000, 13'h17FF, 13'h1800};
  int nErrors = 0;
  int totalChecks = 0;
  int cycles = 0;
  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;
  ssp_status_protect #(.WRITE_CYCLES(WCYC)) ssp_status_protect_inst (.clk_sys(clk_sys),
    .nrst(nrst), .csN(csN), .sck(sck), .si(si), .wpN(wpN), .so(so), .soOeN(soOeN),
    .arrayWrReq(arrayWrReq), .arrayWrAddr(arrayWrAddr), .arrayWrGo(arrayWrGo),
    .arrayBusy(arrayBusy), .statusView(statusView), .hwProtect(hwProtect));
  ssp_host_model ssp_host_model_inst (.csN(csN), .sck(sck), .si(si), .so(so), .soOeN(soOeN));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic endSim();
    $display("Checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    ssp_host_model_inst.frame(8, {op, 16'h0000}, rx);
  endtask
  // Two status bytes in one frame
  task automatic rds(input logic [7:0] exp);
    ssp_host_model_inst.frame(24, 24'h050000, rx);
    chk(rx[15:8], exp);
    chk(rx[7:0], exp);
  endtask
  task automatic wrs(input logic [7:0] d);
    cmd(8'h06);
    ssp_host_model_inst.frame(16, {8'h01, d, 8'h00}, rx);
  endtask
  // Wait out a write cycle, bounded
  task automatic idle();
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 2000 && arrayBusy !== 1'b0; i++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic arr(input logic [12:0] a, input logic x);
    @(posedge clk_sys) #1;
    arrayWrReq = 1'b1;
    arrayWrAddr = a;
    @(posedge clk_sys) #1;
    arrayWrReq = 1'b0;
    chk({7'h00, arrayWrGo}, {7'h00, x});
  endtask
  // Cycle ceiling against a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      nErrors++;
      endSim();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    chk({7'h00, soOeN}, 8'h01);
    rds(8'h00);
    ssp_host_model_inst.frame(16, 24'h018C00, rx); // Latch clear, so ignored
    rds(8'h00);
    cmd(8'h06);
    rds(8'h02);
    cmd(8'h04);
    rds(8'h00);
    ssp_host_model_inst.frame(9, 24'h060000, rx); // Extra bit voids the command
    rds(8'h00);
    wrs(8'hFF);
    rds(8'h03);
    idle();
    rds(8'h8C);
    wpN = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    chk({7'h00, hwProtect}, 8'h01);
    wrs(8'h00);
    rds(8'h8E);
    arr(13'h0000, 1'b0);
    wpN = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    chk({7'h00, hwProtect}, 8'h00);
    // Every guard code against both sides of each boundary
    for (int i = 0; i < 4; i++) begin
      g = i[1:0];
      wrs({4'h8, g, 2'h0});
      idle();
      for (int j = 0; j < 4; j++) begin
        e = !(g == 2'h3 || (g == 2'h2 && adr[j] >= 13'h1000)
          || (g == 2'h1 && adr[j] >= 13'h1800));
        cmd(8'h06);
        arr(adr[j], e);
        if (e) begin
          repeat (3) @(posedge clk_sys);
          arr(adr[j], 1'b0);
          chk({7'h00, arrayBusy}, 8'h01);
          idle();
          chk(statusView, {4'h8, g, 2'h0});
        end
      end
    end
    endSim();
  end
endmodule // ssp_status_protect_tb_top
bind ssp_status_protect ssp_status_protect_props #(.WRITE_CYCLES(WRITE_CYCLES))
  ssp_status_protect_props_inst (.clk_sys(clk_sys), .nrst(nrst), .csN(csN), .sck(sck),
  .si(si), .wpN(wpN), .so(so), .soOeN(soOeN), .arrayWrReq(arrayWrReq),
  .arrayWrAddr(arrayWrAddr), .arrayWrGo(arrayWrGo), .arrayBusy(arrayBusy),
  .statusView(statusView), .hwProtect(hwProtect));
`default_nettype wire
